//--- core/rf_wake_poll_map.vh
`ifndef RF_WAKE_POLL_MAP_VH
`define RF_WAKE_POLL_MAP_VH
// register indices; byte address is four times the index
`define IDX_STIM_TRIM      8'h03
`define IDX_SLICE_LEVEL    8'h0A
`define IDX_DETECT_LEVEL   8'h0B
`define IDX_RADIO_CTRL     8'h0C
`define IDX_OUTSEL_STEP    8'h0D
`define IDX_STIM_CFG       8'h0E
`define IDX_SLICER_CFG     8'h0F
`define IDX_WAKE_DATA_DLY  8'h13
`define IDX_WAKE_IND_TIME  8'h16
`define IDX_WAKE_RSSI_DLY  8'h18
`define IDX_SLEEP_TIME     8'h19
`define IDX_PWRUP_DWELL    8'h1A
`define IDX_PRECLK_DLY     8'h1B
`define IDX_POLL_CTRL      8'h20
`define IDX_POLL_STATUS    8'h21
// field positions
`define BIT_WAKE_ON_SS     5
`define BIT_STEP_SELECT    3
`define BIT_CLAMP_EN       4
`define BIT_CONT_STIM      5
`define BIT_POLL_ENABLE    0
`define BIT_FAST_START     1
// reset values
`define RST_REG            8'h00
`define RST_POLL_CTRL      8'h00
// timing
`define CLK_SYS_HZ         25000000
`define RC_CLK_HZ          10000
`define RC_TICK_CYCLES     (`CLK_SYS_HZ / `RC_CLK_HZ)
`define STEP_FINE_US       500
`define STEP_COARSE_US     64000
`define RC_PERIOD_US       100
`define STEP_FINE_TICKS    (`STEP_FINE_US / `RC_PERIOD_US)
`define STEP_COARSE_TICKS  (`STEP_COARSE_US / `RC_PERIOD_US)
`endif

//--- core/rf_wake_poll_sequencer.v
// What this block does
// (R1) polled listen powers down receiver and crystal
// (R2) after sleep, wake receiver and check energy
// (R3) energy found: enter full receive, recover data
// (R4) no energy: back to sleep, next interval
// (R5) index 0x0c bit5 enables wake on strength
// (R6) index 0x0b is the energy detect level
// (R7) index 0x0d bit3: 0.5 ms or 64 ms step
// (R8) index 0x19 sets receiver off time
// (R9) off time is count times step, RC ticks; a count of 0 gives one step
// (R10) wait powerup dwell from index 0x1a
// (R11) wait index 0x18 before strength sample
// (R12) wait index 0x13 before first data sample
// (R13) wake indication lasts index 0x16 duration
// (R14) wait index 0x1b from detect to preclock
// (R15) timers run on 10 kHz RC tick
// (R16) fast start stimulus required in polled listen
// (R17) index 0x0e bit4 clamp, bit5 continuous stimulus
// (R18) index 0x03 trims stimulus oscillator
// (R19) index 0x0f bits3:2 select slicer mode
// (R20) index 0x0f bits1:0 select hysteresis
// (R21) fixed mode compares slicer to index 0x0a
// (R22) average mode needs transmitter header; this block has no average mode, dataBit holds outside the fixed modes
`timescale 1ns/100ps
`default_nettype none
`include "rf_wake_poll_map.vh"
module rf_wake_poll_sequencer #(
   parameter RC_DIV = `RC_TICK_CYCLES
)(
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   input  wire [7:0]  signalStrength,
   input  wire [7:0]  slicerLevel,
   output reg         receiverOn,
   output reg         crystalOn,
   output reg         stimulusOn,
   output wire        clampEnable,
   output wire [7:0]  stimulusTrim,
   output wire [1:0]  slicerHysteresis,
   output wire [1:0]  slicerModeSelect,
   output reg         dataSample,
   output reg         dataBit,
   output reg         preClock,
   output reg         wakeIndicate
);
   localparam S_IDLE  = 7'b0000001;
   localparam S_SLEEP = 7'b0000010;
   localparam S_DWELL = 7'b0000100;
   localparam S_RSSI  = 7'b0001000;
   localparam S_RXDLY = 7'b0010000;
   localparam S_PRECK = 7'b0100000;
   localparam S_RX    = 7'b1000000;
   localparam [15:0] FINE   = `STEP_FINE_TICKS;
   localparam [15:0] COARSE = `STEP_COARSE_TICKS;

   reg  [7:0]  stimTrim_q, sliceLevel_q, detectLevel_q, radioCtrl_q, outSel_q;
   reg  [7:0]  stimCfg_q, slicerCfg_q, dataDly_q, indTime_q, rssiDly_q;
   reg  [7:0]  sleepTime_q, dwell_q, preClkDly_q, pollCtrl_q;
   reg  [6:0]  state_q;
   reg  [15:0] rcDiv_q;
   reg         rcTick_q;
   reg  [15:0] stepCnt_q;
   reg  [7:0]  cnt_q;
   reg  [7:0]  indCnt_q;
   reg  [7:0]  dataCnt_q;
   reg         dataWait_q;
   reg         ackPending_q;
   reg  [7:0]  ss1_q, ss2_q, sl1_q, sl2_q;
   reg         energySeen_q;
   wire        pollEn   = pollCtrl_q[`BIT_POLL_ENABLE];
   wire        fastEn   = pollCtrl_q[`BIT_FAST_START];
   wire        wakeOnSs = radioCtrl_q[`BIT_WAKE_ON_SS];
   wire [15:0] stepLen  = outSel_q[`BIT_STEP_SELECT] ? COARSE : FINE; // R7
   wire        wrOk     = avs_write & avs_byteenable[0] & ackPending_q;

   // one-cycle answer: waitrequest high on first cycle, low on second
   assign avs_waitrequest  = (avs_read | avs_write) & ~ackPending_q;
   assign clampEnable      = stimCfg_q[`BIT_CLAMP_EN]; // R17
   assign stimulusTrim     = stimTrim_q; // R18
   assign slicerHysteresis = slicerCfg_q[1:0]; // R20
   assign slicerModeSelect = slicerCfg_q[3:2]; // R19

   always @(posedge clk_sys)
   begin
      if (rst)
         ackPending_q <= 1'b0;
      else
         ackPending_q <= (avs_read | avs_write) & ~ackPending_q;
   end

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         stimTrim_q    <= `RST_REG;
         sliceLevel_q  <= `RST_REG;
         detectLevel_q <= `RST_REG;
         radioCtrl_q   <= `RST_REG;
         outSel_q      <= `RST_REG;
         stimCfg_q     <= `RST_REG;
         slicerCfg_q   <= `RST_REG;
         dataDly_q     <= `RST_REG;
         indTime_q     <= `RST_REG;
         rssiDly_q     <= `RST_REG;
         sleepTime_q   <= `RST_REG;
         dwell_q       <= `RST_REG;
         preClkDly_q   <= `RST_REG;
         pollCtrl_q    <= `RST_POLL_CTRL;
      end
      else if (wrOk)
      begin
         case (avs_address)
            `IDX_STIM_TRIM:     stimTrim_q    <= avs_writedata[7:0];
            `IDX_SLICE_LEVEL:   sliceLevel_q  <= avs_writedata[7:0];
            `IDX_DETECT_LEVEL:  detectLevel_q <= avs_writedata[7:0];
            `IDX_RADIO_CTRL:    radioCtrl_q   <= avs_writedata[7:0];
            `IDX_OUTSEL_STEP:   outSel_q      <= avs_writedata[7:0];
            `IDX_STIM_CFG:      stimCfg_q     <= avs_writedata[7:0];
            `IDX_SLICER_CFG:    slicerCfg_q   <= avs_writedata[7:0];
            `IDX_WAKE_DATA_DLY: dataDly_q     <= avs_writedata[7:0];
            `IDX_WAKE_IND_TIME: indTime_q     <= avs_writedata[7:0];
            `IDX_WAKE_RSSI_DLY: rssiDly_q     <= avs_writedata[7:0];
            `IDX_SLEEP_TIME:    sleepTime_q   <= avs_writedata[7:0];
            `IDX_PWRUP_DWELL:   dwell_q       <= avs_writedata[7:0];
            `IDX_PRECLK_DLY:    preClkDly_q   <= avs_writedata[7:0];
            `IDX_POLL_CTRL:     pollCtrl_q    <= avs_writedata[7:0];
            default:            pollCtrl_q    <= pollCtrl_q;
         endcase
      end
   end

   // unmapped indices read zero, writes to them are dropped
   always @(posedge clk_sys)
   begin
      if (rst)
         avs_readdata <= 32'h00000000;
      else if (avs_read & ~ackPending_q)
      begin
         case (avs_address)
            `IDX_STIM_TRIM:     avs_readdata <= {24'h000000, stimTrim_q};
            `IDX_SLICE_LEVEL:   avs_readdata <= {24'h000000, sliceLevel_q};
            `IDX_DETECT_LEVEL:  avs_readdata <= {24'h000000, detectLevel_q};
            `IDX_RADIO_CTRL:    avs_readdata <= {24'h000000, radioCtrl_q};
            `IDX_OUTSEL_STEP:   avs_readdata <= {24'h000000, outSel_q};
            `IDX_STIM_CFG:      avs_readdata <= {24'h000000, stimCfg_q};
            `IDX_SLICER_CFG:    avs_readdata <= {24'h000000, slicerCfg_q};
            `IDX_WAKE_DATA_DLY: avs_readdata <= {24'h000000, dataDly_q};
            `IDX_WAKE_IND_TIME: avs_readdata <= {24'h000000, indTime_q};
            `IDX_WAKE_RSSI_DLY: avs_readdata <= {24'h000000, rssiDly_q};
            `IDX_SLEEP_TIME:    avs_readdata <= {24'h000000, sleepTime_q};
            `IDX_PWRUP_DWELL:   avs_readdata <= {24'h000000, dwell_q};
            `IDX_PRECLK_DLY:    avs_readdata <= {24'h000000, preClkDly_q};
            `IDX_POLL_CTRL:     avs_readdata <= {24'h000000, pollCtrl_q};
            `IDX_POLL_STATUS:   avs_readdata <= {23'h000000, energySeen_q, 1'b0, state_q};
            default:            avs_readdata <= 32'h00000000;
         endcase
      end
   end

   // 10 kHz tick stands in for the RC oscillator
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         rcDiv_q  <= 16'h0000;
         rcTick_q <= 1'b0;
      end
      else if (rcDiv_q == RC_DIV[15:0] - 16'h0001)
      begin
         rcDiv_q  <= 16'h0000;
         rcTick_q <= 1'b1; // R15
      end
      else
      begin
         rcDiv_q  <= rcDiv_q + 16'h0001;
         rcTick_q <= 1'b0;
      end
   end

   // external analog inputs, synchronised
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         ss1_q <= 8'h00;
         ss2_q <= 8'h00;
         sl1_q <= 8'h00;
         sl2_q <= 8'h00;
      end
      else
      begin
         ss1_q <= signalStrength;
         ss2_q <= ss1_q;
         sl1_q <= slicerLevel;
         sl2_q <= sl1_q;
      end
   end

   // energy decision: only when wake on strength is set
   wire energy = wakeOnSs & (ss2_q > detectLevel_q); // R5 R6

   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_q      <= S_IDLE;
         stepCnt_q    <= 16'h0000;
         cnt_q        <= 8'h00;
         energySeen_q <= 1'b0;
         receiverOn   <= 1'b0;
         crystalOn    <= 1'b0;
         stimulusOn   <= 1'b0;
         preClock     <= 1'b0;
      end
      else
      begin
         preClock <= 1'b0;
         stimulusOn <= stimCfg_q[`BIT_CONT_STIM]; // R17
         case (state_q)
            S_IDLE:
            begin
               if (pollEn)
               begin
                  state_q    <= S_SLEEP;
                  receiverOn <= 1'b0; // R1
                  crystalOn  <= 1'b0; // R1
                  cnt_q      <= sleepTime_q; // R8
                  stepCnt_q  <= 16'h0000;
               end
               else
               begin
                  receiverOn <= 1'b1;
                  crystalOn  <= 1'b1;
               end
            end
            S_SLEEP:
            begin
               if (!pollEn)
                  state_q <= S_IDLE;
               else if (rcTick_q)
               begin
                  // a zero count wakes on the next step boundary
                  if (stepCnt_q >= stepLen - 16'h0001)
                  begin
                     stepCnt_q <= 16'h0000;
                     if (cnt_q <= 8'h01) // R9
                     begin
                        state_q    <= S_DWELL; // R2
                        receiverOn <= 1'b1;
                        crystalOn  <= 1'b1;
                        stimulusOn <= fastEn | stimCfg_q[`BIT_CONT_STIM]; // R16
                        cnt_q      <= dwell_q; // R10
                     end
                     else
                        cnt_q <= cnt_q - 8'h01;
                  end
                  else
                     stepCnt_q <= stepCnt_q + 16'h0001;
               end
            end
            S_DWELL:
            begin
               stimulusOn <= fastEn | stimCfg_q[`BIT_CONT_STIM]; // R16
               if (rcTick_q)
               begin
                  if (cnt_q == 8'h00)
                  begin
                     state_q <= S_RSSI;
                     cnt_q   <= rssiDly_q; // R11
                  end
                  else
                     cnt_q <= cnt_q - 8'h01; // R10
               end
            end
            S_RSSI:
            begin
               if (rcTick_q)
               begin
                  if (cnt_q != 8'h00)
                     cnt_q <= cnt_q - 8'h01; // R11
                  else if (energy)
                  begin
                     state_q      <= S_PRECK; // R3
                     energySeen_q <= 1'b1;
                     cnt_q        <= preClkDly_q; // R14
                  end
                  else
                  begin
                     state_q    <= S_SLEEP; // R4
                     receiverOn <= 1'b0;
                     crystalOn  <= 1'b0;
                     cnt_q      <= sleepTime_q;
                     stepCnt_q  <= 16'h0000;
                  end
               end
            end
            S_PRECK:
            begin
               if (rcTick_q)
               begin
                  if (cnt_q == 8'h00)
                  begin
                     preClock <= 1'b1; // R14
                     state_q  <= S_RX;
                  end
                  else
                     cnt_q <= cnt_q - 8'h01;
               end
            end
            S_RX:
            begin
               // full receive holds until software drops polling
               if (!pollEn)
               begin
                  state_q      <= S_IDLE;
                  energySeen_q <= 1'b0;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // data sampling delay counted from receiver wake
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         dataCnt_q  <= 8'h00;
         dataWait_q <= 1'b0;
         dataSample <= 1'b0;
         dataBit    <= 1'b0;
      end
      else
      begin
         if (state_q == S_SLEEP || state_q == S_IDLE && pollEn)
         begin
            dataWait_q <= 1'b1;
            dataCnt_q  <= dataDly_q;
            dataSample <= 1'b0;
         end
         else if (dataWait_q && rcTick_q)
         begin
            if (dataCnt_q == 8'h00)
            begin
               dataWait_q <= 1'b0;
               dataSample <= 1'b1; // R12
            end
            else
               dataCnt_q <= dataCnt_q - 8'h01;
         end
         else if (!pollEn)
            dataSample <= 1'b1;
         if (dataSample && (slicerCfg_q[3:2] == 2'b00 || slicerCfg_q[3:2] == 2'b11))
            dataBit <= sl2_q > sliceLevel_q; // R21
      end
   end

   // wake indication pulse length
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         indCnt_q     <= 8'h00;
         wakeIndicate <= 1'b0;
      end
      else if (state_q == S_RSSI && rcTick_q && cnt_q == 8'h00 && energy)
      begin
         indCnt_q     <= indTime_q;
         wakeIndicate <= indTime_q != 8'h00; // R13
      end
      else if (wakeIndicate && rcTick_q)
      begin
         if (indCnt_q == 8'h01)
            wakeIndicate <= 1'b0;
         indCnt_q <= indCnt_q - 8'h01; // R13
      end
   end
endmodule // rf_wake_poll_sequencer
`default_nettype wire

//--- dv/rf_wake_poll_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "rf_wake_poll_map.vh"
module rf_wake_poll_props #(
   parameter RC_DIV = 4
)(
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [7:0]  signalStrength,
   input wire logic [7:0]  slicerLevel,
   input wire logic        receiverOn,
   input wire logic        crystalOn,
   input wire logic        stimulusOn,
   input wire logic        clampEnable,
   input wire logic [7:0]  stimulusTrim,
   input wire logic [1:0]  slicerHysteresis,
   input wire logic [1:0]  slicerModeSelect,
   input wire logic        dataSample,
   input wire logic        dataBit,
   input wire logic        preClock,
   input wire logic        wakeIndicate
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   wire wrOk = avs_write && !avs_waitrequest && avs_byteenable[0];
   a_one_wait: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("access not answered after one wait");
   a_rx_xtal_pair: assert property (receiverOn == crystalOn)
      else $error("receiver and crystal power differ");
   a_trim_follow: assert property (wrOk && avs_address == `IDX_STIM_TRIM |=>
      stimulusTrim == $past(avs_writedata[7:0])) else $error("trim output wrong");
   a_clamp_follow: assert property (wrOk && avs_address == `IDX_STIM_CFG |=>
      clampEnable == $past(avs_writedata[4])) else $error("clamp output wrong");
   a_slicer_follow: assert property (wrOk && avs_address == `IDX_SLICER_CFG |=>
      slicerModeSelect == $past(avs_writedata[3:2]) && slicerHysteresis == $past(avs_writedata[1:0]))
      else $error("slicer fields wrong");
   a_preclk_single: assert property (preClock |=> !preClock)
      else $error("preclock longer than one cycle");
   a_preclk_rx: assert property (preClock |-> receiverOn)
      else $error("preclock with receiver off");
   a_wake_rx: assert property (wakeIndicate |-> receiverOn)
      else $error("wake indication with receiver off");
   a_sleep_min: assert property ($fell(receiverOn) |=> !receiverOn [*8])
      else $error("sleep shorter than one step");
endmodule // rf_wake_poll_props
bind rf_wake_poll_sequencer rf_wake_poll_props #(.RC_DIV(RC_DIV)) u_props (
   .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .signalStrength(signalStrength), .slicerLevel(slicerLevel), .receiverOn(receiverOn),
   .crystalOn(crystalOn), .stimulusOn(stimulusOn), .clampEnable(clampEnable),
   .stimulusTrim(stimulusTrim), .slicerHysteresis(slicerHysteresis),
   .slicerModeSelect(slicerModeSelect), .dataSample(dataSample), .dataBit(dataBit),
   .preClock(preClock), .wakeIndicate(wakeIndicate));
`default_nettype wire

//--- dv/rf_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module rf_front_model (
   input  wire logic       clk_sys,
   input  wire logic       receiverOn,
   input  wire logic [7:0] strengthCmd,
   input  wire logic [7:0] levelCmd,
   input  wire logic       headerOn,
   output logic [7:0]      signalStrength,
   output logic [7:0]      slicerLevel
);
   logic toggle_q = 1'b0;
   always @(posedge clk_sys)
      toggle_q <= ~toggle_q;
   // powered-down front end measures nothing
   assign signalStrength = receiverOn ? strengthCmd : 8'h00;
   // alternating header lets an averaging slicer settle
   assign slicerLevel = headerOn ? (toggle_q ? 8'hC0 : 8'h40) : levelCmd;
endmodule // rf_front_model
`default_nettype wire

//--- dv/rf_wake_poll_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module rf_wake_poll_sequencer_test;
   localparam int RcDiv = 4;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [7:0]  strengthCmd = 8'h00;
   logic [7:0]  levelCmd = 8'h00;
   logic        headerOn = 1'b0;
   wire  [31:0] avs_readdata;
   wire         avs_waitrequest, receiverOn, crystalOn, stimulusOn, clampEnable, dataSample;
   wire         dataBit, preClock, wakeIndicate;
   wire  [7:0]  signalStrength, slicerLevel, stimulusTrim;
   wire  [1:0]  slicerHysteresis, slicerModeSelect;
   logic [31:0] rdq;
   int          error_cnt = 0;
   int          n_checks = 0;
   int          i, c;
   logic [7:0]  idx [13] = '{8'h03, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h13, 8'h16,
                             8'h18, 8'h19, 8'h1A, 8'h1B};
   logic [7:0]  pa [10] = '{8'h19, 8'h0D, 8'h1A, 8'h18, 8'h13, 8'h16, 8'h1B, 8'h0B, 8'h0C, 8'h20};
   logic [7:0]  pd [10] = '{8'h02, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h50, 8'h00, 8'h03};
   rf_wake_poll_sequencer #(.RC_DIV(RcDiv)) u_dut (
      .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .signalStrength(signalStrength), .slicerLevel(slicerLevel), .receiverOn(receiverOn),
      .crystalOn(crystalOn), .stimulusOn(stimulusOn), .clampEnable(clampEnable),
      .stimulusTrim(stimulusTrim), .slicerHysteresis(slicerHysteresis),
      .slicerModeSelect(slicerModeSelect), .dataSample(dataSample), .dataBit(dataBit),
      .preClock(preClock), .wakeIndicate(wakeIndicate));
   rf_front_model u_front (
      .clk_sys(clk_sys), .receiverOn(receiverOn), .strengthCmd(strengthCmd),
      .levelCmd(levelCmd), .headerOn(headerOn), .signalStrength(signalStrength),
      .slicerLevel(slicerLevel));
   always #20 clk_sys = ~clk_sys;
   task check(input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (seen !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // one access; request held until waitrequest is sampled low
   task bus(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      begin
         n = 0;
         avs_address <= a;
         avs_writedata <= {24'h0, d};
         avs_read <= rd;
         avs_write <= !rd;
         @(posedge clk_sys);
         while (avs_waitrequest !== 1'b0 && n < 50)
         begin
            @(posedge clk_sys);
            n = n + 1;
         end
         q = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
         @(posedge clk_sys);
         if (n >= 50)
            check(0, 1);
      end
   endtask
   // sel 0 receiver, 1 wake indication, 2 preclock
   task wait_for(input int sel, input logic val, output int cyc);
      begin
         cyc = 0;
         while ((sel == 0 ? receiverOn : sel == 1 ? wakeIndicate : preClock) !== val
                && cyc < 4000)
         begin
            @(posedge clk_sys);
            cyc = cyc + 1;
         end
         if (cyc >= 4000)
            check(0, 1);
      end
   endtask
   task report_and_stop;
      begin
         $display("errors %0d checks %0d", error_cnt, n_checks);
         if (error_cnt == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial
   begin
      #400000;
      error_cnt = error_cnt + 1;
      report_and_stop;
   end
   initial
   begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      for (i = 0; i < 13; i++)
      begin
         bus(1, idx[i], 8'h00, rdq);
         check(rdq, 32'h0);
         bus(0, idx[i], 8'h5A ^ i[7:0], rdq);
         bus(1, idx[i], 8'h00, rdq);
         check(rdq, {24'h0, 8'h5A ^ i[7:0]});
      end
      bus(0, 8'h05, 8'hFF, rdq);
      bus(1, 8'h05, 8'h00, rdq);
      check(rdq, 32'h0);
      avs_byteenable <= 4'h0;
      bus(0, 8'h03, 8'h11, rdq);
      avs_byteenable <= 4'hF;
      check(stimulusTrim, 8'h5A);
      bus(0, 8'h0E, 8'h10, rdq);
      check(clampEnable, 1);
      bus(0, 8'h0E, 8'h20, rdq);
      check(clampEnable, 0);
      @(posedge clk_sys);
      check(stimulusOn, 1);
      bus(0, 8'h0E, 8'h10, rdq);
      for (i = 0; i < 16; i++)
      begin
         bus(0, 8'h0F, i[7:0], rdq);
         check({slicerModeSelect, slicerHysteresis}, i[3:0]);
      end
      // fixed slicing in both encodings of the fixed mode
      bus(0, 8'h0A, 8'h80, rdq);
      for (i = 0; i < 2; i++)
      begin
         bus(0, 8'h0F, i[0] ? 8'h0C : 8'h00, rdq);
         levelCmd <= 8'h90;
         repeat (6) @(posedge clk_sys);
         check({dataSample, dataBit}, 2'b11);
         levelCmd <= 8'h70;
         repeat (6) @(posedge clk_sys);
         check(dataBit, 0);
      end
      bus(0, 8'h0F, 8'h04, rdq);
      headerOn <= 1'b1;
      levelCmd <= 8'h90;
      repeat (8) @(posedge clk_sys);
      headerOn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check(dataBit, 0);
      // polling with a strong carrier but wake on strength off
      strengthCmd <= 8'hA0;
      for (i = 0; i < 10; i++)
         bus(0, pa[i], pd[i], rdq);
      wait_for(0, 0, c);
      check(crystalOn, 0);
      check({stimulusOn, dataSample}, 2'b00);
      wait_for(0, 1, c);
      check(c >= 9 * RcDiv && c <= 11 * RcDiv, 1);
      check(stimulusOn, 1);
      wait_for(0, 0, c);
      check(c >= 3 * RcDiv && c <= 6 * RcDiv, 1);
      check(wakeIndicate, 0);
      bus(0, 8'h0C, 8'h20, rdq);
      wait_for(0, 1, c);
      wait_for(1, 1, c);
      check(c <= 6 * RcDiv, 1);
      wait_for(1, 0, c);
      check(c >= RcDiv - 1 && c <= 2 * RcDiv, 1);
      wait_for(2, 1, c);
      check(c <= 5 * RcDiv, 1);
      repeat (40) @(posedge clk_sys);
      check({receiverOn, dataSample}, 2'b11);
      bus(1, 8'h21, 8'h00, rdq);
      check(rdq, 32'h00000140);
      // coarse step, one step of sleep
      bus(0, 8'h20, 8'h00, rdq);
      bus(0, 8'h0C, 8'h00, rdq);
      bus(0, 8'h0D, 8'h08, rdq);
      bus(0, 8'h19, 8'h01, rdq);
      bus(0, 8'h20, 8'h01, rdq);
      wait_for(0, 0, c);
      wait_for(0, 1, c);
      check(c >= 639 * RcDiv && c <= 641 * RcDiv, 1);
      report_and_stop;
   end
endmodule // rf_wake_poll_sequencer_test
`default_nettype wire
